// ### hw/blcc_host.sv
// Host-side controller driving the charger and power-hold pins of a
// handset power-management device; status and orders over Wishbone.
// Assumes the device pins arrive asynchronously and the battery monitor
// is digitised outside into a single "final voltage reached" level.
//
// Behaviour
// - Processor finds chemistry after startup and then sets charger mode.
// - Lithium: hold mode-disable low; device charges at 160 mV full current.
// - After charge-done processor may continue, or end with both pins high.
// - Nickel: drive mode-disable high; gate drive handed to processor.
// - Nickel: sample monitor only with pass transistor off; stop at final voltage.
//
// The implementer's own choices: the Wishbone register port and the placing of the registers.
`timescale 1ns/1ps
module blcc_host
    import blcc_pkg::*;
(
    input wire logic core_clk,
    input wire logic reset,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [blcc_pkg::ADR_W-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic device_reset_n,
    input wire logic adapter_detect,
    input wire logic charge_done,
    input wire logic battery_final_in,
    output logic power_hold_in,
    output logic oscillator_supply_enable,
    output logic lithium_mode_disable,
    output logic gate_override_in
);
    typedef struct packed {
        blcc_state_t state;
        logic [CTRL_W-1:0] ctrl;
        logic [PULSE_W-1:0] on_len;
        logic [PULSE_W-1:0] off_len;
        logic [PULSE_W-1:0] cnt;
        logic [3:0] sync1;
        logic [3:0] sync2;
        logic finished;
        logic hold;
        logic osc;
        logic mdis;
        logic gate;
        logic ack;
        logic [31:0] dat;
    } blcc_regs_t;

    blcc_regs_t r_reg;
    blcc_regs_t r_next;

    function automatic logic [31:0] merge_bytes(input logic [31:0] old_v,
                                                input logic [31:0] new_v,
                                                input logic [3:0] sel);
        logic [31:0] res;
        res = old_v;
        for (int i = 0; i < 4; i++) begin
            if (sel[i]) begin
                res[i*8 +: 8] = new_v[i*8 +: 8];
            end
        end
        return res;
    endfunction

    logic ready;
    logic adapter;
    logic done;
    logic at_final;
    logic monitor_on;
    logic wr;
    logic rd;
    logic [31:0] ctrl_word;
    logic [31:0] pulse_word;
    logic [31:0] status_word;
    logic [31:0] wr_ctrl;
    logic [31:0] wr_pulse;

    assign ready = r_reg.sync2[0];
    assign adapter = r_reg.sync2[1];
    assign done = r_reg.sync2[2];
    assign at_final = r_reg.sync2[3];
    assign monitor_on = r_reg.hold & r_reg.osc;
    assign wr = wb_cyc_i & wb_stb_i & wb_we_i & ~r_reg.ack;
    assign rd = wb_cyc_i & wb_stb_i & ~r_reg.ack;
    assign ctrl_word = {27'h0000000, r_reg.ctrl};
    assign pulse_word = {r_reg.off_len, r_reg.on_len};
    assign status_word = {19'h00000, r_reg.state, 3'h0, monitor_on, r_reg.finished,
                          done, adapter, ready};
    assign wr_ctrl = merge_bytes(ctrl_word, wb_dat_i, wb_sel_i);
    assign wr_pulse = merge_bytes(pulse_word, wb_dat_i, wb_sel_i);

    always_comb begin
        r_next = r_reg;
        r_next.sync1 = {battery_final_in, charge_done, adapter_detect, device_reset_n};
        r_next.sync2 = r_reg.sync1;
        r_next.ack = rd;
        r_next.dat = 32'h00000000;
        if (rd && !wb_we_i) begin
            case (wb_adr_i)
                ADR_CTRL: r_next.dat = ctrl_word;
                ADR_PULSE: r_next.dat = pulse_word;
                ADR_STATUS: r_next.dat = status_word;
                default: r_next.dat = 32'h00000000;
            endcase
        end
        if (wr && wb_adr_i == ADR_CTRL) begin
            r_next.ctrl = wr_ctrl[CTRL_W-1:0];
        end
        if (wr && wb_adr_i == ADR_PULSE) begin
            r_next.on_len = wr_pulse[PULSE_W-1:0];
            r_next.off_len = wr_pulse[2*PULSE_W-1:PULSE_W];
        end
        if (wr && wb_adr_i == ADR_STATUS && wb_sel_i[0] && wb_dat_i[ST_FINISHED]) begin
            r_next.finished = 1'b0;
        end
        r_next.cnt = r_reg.cnt + 16'h0001;
        case (r_reg.state)
            S_IDLE: begin
                r_next.cnt = 16'h0000;
                // Chemistry is only applied once the processor side is out of reset
                if (ready && adapter && r_reg.ctrl[CTRL_CHARGE]) begin
                    r_next.state = r_reg.ctrl[CTRL_NICKEL] ? S_NI_ON : S_LI;
                end
            end
            S_LI: begin
                if (done && r_reg.ctrl[CTRL_TERM]) begin
                    r_next.state = S_STOP;
                end
            end
            S_NI_ON: begin
                if (r_reg.cnt >= r_reg.on_len) begin
                    r_next.state = S_NI_OFF;
                    r_next.cnt = 16'h0000;
                end
            end
            S_NI_OFF: begin
                // Sample only after the monitor settled with the transistor off
                if (r_reg.cnt == 16'(SETTLE_CYC) && monitor_on && at_final) begin
                    r_next.state = S_STOP;
                end else if (r_reg.cnt >= r_reg.off_len) begin
                    r_next.state = S_NI_ON;
                    r_next.cnt = 16'h0000;
                end
            end
            S_STOP: begin
                r_next.finished = 1'b1;
                r_next.cnt = 16'h0000;
            end
            default: r_next.state = S_IDLE;
        endcase
        // Losing the adapter, reset or the enable abandons any charge phase
        if (!ready || !adapter || !r_reg.ctrl[CTRL_CHARGE]) begin
            r_next.state = S_IDLE;
        end
        r_next.hold = r_reg.ctrl[CTRL_HOLD];
        r_next.osc = r_reg.ctrl[CTRL_OSC];
        case (r_next.state)
            S_LI: begin
                r_next.mdis = 1'b0;
                r_next.gate = 1'b0;
            end
            S_NI_ON: begin
                r_next.mdis = 1'b1;
                r_next.gate = 1'b0;
            end
            default: begin
                r_next.mdis = 1'b1;
                r_next.gate = 1'b1;
            end
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            r_reg <= '{state: S_IDLE, ctrl: CTRL_RST, on_len: PULSE_ON_RST,
                       off_len: PULSE_OFF_RST, mdis: 1'b1, gate: 1'b1, default: '0};
        end else begin
            r_reg <= r_next;
        end
    end

    assign wb_dat_o = r_reg.dat;
    assign wb_ack_o = r_reg.ack;
    assign power_hold_in = r_reg.hold;
    assign oscillator_supply_enable = r_reg.osc;
    assign lithium_mode_disable = r_reg.mdis;
    assign gate_override_in = r_reg.gate;

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (reset);

    AST_LI_PINS: assert property (r_reg.state == S_LI |-> !lithium_mode_disable && !gate_override_in)
        else $error("lithium state without mode-disable low");
    AST_NI_PINS: assert property ((r_reg.state & (S_NI_ON | S_NI_OFF)) != 0 |-> lithium_mode_disable)
        else $error("nickel state without mode-disable high");
    AST_STOP_PINS: assert property (r_reg.state == S_STOP |-> lithium_mode_disable && gate_override_in)
        else $error("stopped charging but pins not both high");
    AST_LI_TERM: assert property (r_reg.state == S_LI && done && r_reg.ctrl[CTRL_TERM] && ready && adapter && r_reg.ctrl[CTRL_CHARGE] |=> r_reg.state == S_STOP ##0 gate_override_in)
        else $error("charge-done with terminate did not stop");
    AST_NI_OFF_GATE: assert property (r_reg.state == S_NI_OFF |-> gate_override_in)
        else $error("sampling state with pass transistor on");
    AST_NI_FINAL_SAMPLE: assert property ($rose(r_reg.state == S_STOP) && $past(r_reg.state) == S_NI_OFF |-> $past(r_reg.cnt) == 16'(SETTLE_CYC) && $past(monitor_on))
        else $error("nickel stop without settled monitor sample");
    AST_START_NEEDS_READY: assert property ($past(r_reg.state) == S_IDLE && r_reg.state != S_IDLE |-> $past(ready) && $past(r_reg.ctrl[CTRL_CHARGE]))
        else $error("charging started before device ready");
    AST_MONITOR: assert property (status_word[ST_MONITOR] == (power_hold_in && oscillator_supply_enable))
        else $error("monitor flag mismatched to enables");
    AST_PULSE_ON: assert property ($rose(r_reg.state == S_NI_OFF) |-> $past(r_reg.cnt) >= $past(r_reg.on_len))
        else $error("pulse ended before on time");
    AST_ACK_ONE: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held two cycles");

    COV_LI_TERM: cover property (r_reg.state == S_LI ##1 r_reg.state == S_STOP);
    COV_NI_PULSE: cover property (r_reg.state == S_NI_ON ##[1:300] r_reg.state == S_NI_OFF);
    COV_NI_STOP: cover property (r_reg.state == S_NI_OFF ##1 r_reg.state == S_STOP);
endmodule // blcc_host

// ### hw/blcc_pkg.sv
// Constants for the battery lockout / charge host controller.
// Assumes a 40 MHz core clock and a classic Wishbone register port.
package blcc_pkg;
    localparam int CLK_PERIOD_NS = 25;
    // Battery monitor settle time after the pass transistor turns off
    localparam int SETTLE_TIME_NS = 1000;
    localparam int SETTLE_CYC = (SETTLE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    localparam int ADR_W = 8;
    localparam logic [7:0] ADR_CTRL = 8'h00;
    localparam logic [7:0] ADR_PULSE = 8'h04;
    localparam logic [7:0] ADR_STATUS = 8'h08;

    // Control register fields
    localparam int CTRL_HOLD = 0;
    localparam int CTRL_OSC = 1;
    localparam int CTRL_NICKEL = 2;
    localparam int CTRL_CHARGE = 3;
    localparam int CTRL_TERM = 4;
    localparam int CTRL_W = 5;
    localparam logic [4:0] CTRL_RST = 5'h00;

    // Pulse register: on-time low half, off-time high half, in clock cycles
    localparam int PULSE_W = 16;
    localparam logic [15:0] PULSE_ON_RST = 16'h0400;
    localparam logic [15:0] PULSE_OFF_RST = 16'h0400;

    // Status register fields
    localparam int ST_READY = 0;
    localparam int ST_ADAPTER = 1;
    localparam int ST_DONE = 2;
    localparam int ST_FINISHED = 3;
    localparam int ST_MONITOR = 4;
    localparam int ST_STATE_LSB = 8;

    typedef enum logic [4:0] {
        S_IDLE = 5'b00001,
        S_LI = 5'b00010,
        S_NI_ON = 5'b00100,
        S_NI_OFF = 5'b01000,
        S_STOP = 5'b10000
    } blcc_state_t;
endpackage

// ### tb/blcc_dev_model.sv
// Behavioural handset power-management device seen from the host pins.
// Assumes the bench sets the analogue conditions as plain levels.
`timescale 1ns/1ps
module blcc_dev_model #(
    parameter int RESET_DLY_CYC = 48
) (
    input wire logic core_clk,
    input wire logic reset,
    input wire logic power_hold_in,
    input wire logic oscillator_supply_enable,
    input wire logic lithium_mode_disable,
    input wire logic gate_override_in,
    input wire logic adapter_on,
    input wire logic eoc_cond,
    input wire logic final_cond,
    input wire logic [12:0] batt_mv,
    input wire logic [7:0] die_temp_c,
    output logic device_reset_n,
    output logic adapter_detect,
    output logic charge_done,
    output logic battery_final_in,
    output logic pass_gate_drive
);
    // Comparator thresholds of the device, in millivolts and degrees
    localparam int LOCK_HI_MV = 3200;
    localparam int LOCK_LO_MV = 3000;
    localparam int DEEP_MV = 2400;
    localparam int HOT_C = 160;
    localparam int COOL_C = 125;
    // Reset delay stands for the capacitor-set timer, scaled to cycles
    int dly;
    logic flip;
    logic powered;
    logic mon_on;
    logic lock_ok;
    logic hot;
    logic rails_on;
    logic trickle;
    assign adapter_detect = adapter_on;
    assign powered = power_hold_in | adapter_detect;
    // Below the lockout level an adapter only trickles, never ends a charge
    assign trickle = adapter_detect & ~lock_ok;
    // Deep discharge cuts the rails even when software left them on
    assign rails_on = powered & lock_ok & ~hot & (batt_mv >= DEEP_MV);
    // Lockout only re-arms while the rails are off
    always_ff @(posedge core_clk) begin
        if (reset) begin
            lock_ok <= 1'b0;
            hot <= 1'b0;
        end else begin
            if (batt_mv > LOCK_HI_MV) begin
                lock_ok <= 1'b1;
            end else if (batt_mv < LOCK_LO_MV && !rails_on) begin
                lock_ok <= 1'b0;
            end
            if (die_temp_c > HOT_C) begin
                hot <= 1'b1;
            end else if (die_temp_c < COOL_C) begin
                hot <= 1'b0;
            end
        end
    end
    // Internal control only in lithium mode, else the host owns the gate
    assign pass_gate_drive = lithium_mode_disable ? gate_override_in : 1'b0;
    assign charge_done = eoc_cond & ~lithium_mode_disable & adapter_detect & ~trickle;
    assign mon_on = power_hold_in & oscillator_supply_enable;
    // A disconnected divider reads as a toggling level, never a held value
    assign battery_final_in = mon_on ? final_cond : flip;
    always_ff @(posedge core_clk) begin
        flip <= reset ? 1'b0 : ~flip;
        if (reset || !rails_on) begin
            dly <= 0;
            device_reset_n <= 1'b0;
        end else if (dly >= RESET_DLY_CYC) begin
            device_reset_n <= 1'b1;
        end else begin
            dly <= dly + 1;
        end
    end
endmodule // blcc_dev_model

// ### tb/tb.sv
// Self-checking bench for the host controller, Wishbone master tasks.
// Assumes one 40 MHz clock and the behavioural device model.
`timescale 1ns/1ps
module tb;
    import blcc_pkg::*;
    logic core_clk, reset, cyc, stb, we, ack;
    logic [7:0] adr;
    logic [3:0] sel;
    logic [31:0] wdat, rdat, r;
    logic rst_n, adp, done, fin, hold, osc, mdis, gate, pgd;
    logic adapter_on, eoc_cond, final_cond;
    logic [12:0] batt_mv;
    logic [7:0] die_temp_c;
    int miscompares, compares;
    blcc_host u_dut(.core_clk(core_clk), .reset(reset), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
        .wb_ack_o(ack), .device_reset_n(rst_n), .adapter_detect(adp), .charge_done(done),
        .battery_final_in(fin), .power_hold_in(hold), .oscillator_supply_enable(osc),
        .lithium_mode_disable(mdis), .gate_override_in(gate));
    blcc_dev_model u_dev(.core_clk(core_clk), .reset(reset), .power_hold_in(hold),
        .oscillator_supply_enable(osc), .lithium_mode_disable(mdis),
        .gate_override_in(gate), .adapter_on(adapter_on), .eoc_cond(eoc_cond),
        .final_cond(final_cond), .batt_mv(batt_mv), .die_temp_c(die_temp_c),
        .device_reset_n(rst_n), .adapter_detect(adp),
        .charge_done(done), .battery_final_in(fin), .pass_gate_drive(pgd));
    initial begin
        core_clk = 1'b0;
        forever #12.5 core_clk = ~core_clk;
    end
    task automatic conclude();
        $display("compares=%0d miscompares=%0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
        compares++;
        if (got !== exp) begin
            miscompares++;
            $display("mismatch at %0t: %s got %h exp %h", $time, m, got, exp);
        end
    endtask
    // Classic cycle: hold everything until ack is sampled high, then release
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        @(posedge core_clk);
        while (ack !== 1'b1) @(posedge core_clk);
        r = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge core_clk);
    endtask
    task automatic wait_st(input logic [4:0] st);
        for (int n = 0; n < 100; n++) begin
            wb(1'b0, ADR_STATUS, 32'h0);
            if (r[12:8] === st) break;
        end
        chk(r[12:8], st, "state");
    endtask
    task automatic wait_rdy(input logic v);
        for (int n = 0; n < 100; n++) begin
            wb(1'b0, ADR_STATUS, 32'h0);
            if (r[ST_READY] === v) break;
        end
        chk(r[ST_READY], v, "device ready");
    endtask
    task automatic t_protect();
        die_temp_c <= 8'ha5;
        repeat (6) @(posedge core_clk);
        wb(1'b0, ADR_STATUS, 32'h0);
        chk(r[ST_READY], 1'b0, "overtemp shutdown");
        die_temp_c <= 8'h82;
        repeat (80) @(posedge core_clk);
        wb(1'b0, ADR_STATUS, 32'h0);
        chk(r[ST_READY], 1'b0, "overtemp hold-off");
        die_temp_c <= 8'h19;
        wait_rdy(1'b1);
        batt_mv <= 13'hb54;
        repeat (80) @(posedge core_clk);
        wb(1'b0, ADR_STATUS, 32'h0);
        chk(r[ST_READY], 1'b1, "running below lockout");
        batt_mv <= 13'h8fc;
        wait_rdy(1'b0);
        batt_mv <= 13'hc1c;
        repeat (80) @(posedge core_clk);
        wb(1'b0, ADR_STATUS, 32'h0);
        chk(r[ST_READY], 1'b0, "lockout blocks start");
        batt_mv <= 13'he10;
        wait_rdy(1'b1);
    endtask
    task automatic t_reset();
        chk({hold, osc, mdis, gate}, 4'b0011, "reset pins");
        wb(1'b0, ADR_CTRL, 32'h0);
        chk(r, 32'h0, "ctrl reset");
        wb(1'b0, ADR_PULSE, 32'h0);
        chk(r, {PULSE_OFF_RST, PULSE_ON_RST}, "pulse reset");
        wb(1'b1, 8'h0c, 32'hffffffff);
        wb(1'b0, 8'h0c, 32'h0);
        chk(r, 32'h0, "unmapped");
        wait_st(5'h01);
        chk(r[ST_READY], 1'b0, "ready while off");
    endtask
    task automatic t_power();
        wb(1'b1, ADR_CTRL, 32'h1);
        wb(1'b0, ADR_STATUS, 32'h0);
        chk(r[ST_MONITOR], 1'b0, "monitor without osc");
        wb(1'b1, ADR_CTRL, 32'h3);
        sel <= 4'h0;
        wb(1'b1, ADR_CTRL, 32'h0);
        sel <= 4'hf;
        wb(1'b0, ADR_CTRL, 32'h0);
        chk(r, 32'h3, "ctrl byte lanes");
        chk({hold, osc}, 2'b11, "hold osc pins");
        wait_rdy(1'b1);
        chk(r[ST_MONITOR], 1'b1, "monitor on");
    endtask
    task automatic t_lithium();
        adapter_on <= 1'b1;
        wb(1'b1, ADR_CTRL, 32'h1b);
        wait_st(5'h02);
        chk({mdis, gate}, 2'b00, "lithium pins");
        chk(pgd, 1'b0, "gate drive internal");
        eoc_cond <= 1'b1;
        wait_st(5'h10);
        wb(1'b0, ADR_STATUS, 32'h0);
        chk({mdis, gate, r[ST_FINISHED]}, 3'b111, "terminate");
        wb(1'b1, ADR_CTRL, 32'h3);
        eoc_cond <= 1'b0;
        wait_st(5'h01);
        wb(1'b1, ADR_STATUS, 32'h8);
        wb(1'b0, ADR_STATUS, 32'h0);
        chk(r[ST_FINISHED], 1'b0, "finished cleared");
    endtask
    task automatic t_nickel();
        int lo;
        int hi;
        wb(1'b1, ADR_PULSE, 32'h003c000a);
        wb(1'b1, ADR_CTRL, 32'h0f);
        for (int n = 0; n < 300 && gate !== 1'b0; n++) @(posedge core_clk);
        chk(mdis, 1'b1, "nickel mode pin");
        for (lo = 0; lo < 300 && gate === 1'b0; lo++) @(posedge core_clk);
        chk(lo, 11, "on time");
        chk(pgd, 1'b1, "gate drive off");
        for (hi = 0; hi < 300 && gate === 1'b1; hi++) @(posedge core_clk);
        chk(hi, 61, "off time without final");
        final_cond <= 1'b1;
        wait_st(5'h10);
        wb(1'b0, ADR_STATUS, 32'h0);
        chk({mdis, gate, r[ST_FINISHED]}, 3'b111, "nickel stop");
        adapter_on <= 1'b0;
        final_cond <= 1'b0;
        wait_st(5'h01);
        chk({mdis, gate}, 2'b11, "adapter lost idle");
    endtask
    initial begin
        repeat (30000) @(posedge core_clk);
        miscompares++;
        conclude();
    end
    initial begin
        reset = 1'b1;
        cyc = 1'b0;
        stb = 1'b0;
        we = 1'b0;
        adr = 8'h0;
        sel = 4'hf;
        wdat = 32'h0;
        adapter_on = 1'b0;
        eoc_cond = 1'b0;
        final_cond = 1'b0;
        batt_mv = 13'he10;
        die_temp_c = 8'h19;
        repeat (12) @(posedge core_clk);
        reset <= 1'b0;
        @(posedge core_clk);
        t_reset();
        t_power();
        t_protect();
        t_lithium();
        t_nickel();
        conclude();
    end
endmodule // tb
